// *** rtl/gpc_port.sv ***
// Four-pin GPIO port with pin-change interrupt flag, mask and enable.
// Assumes a simple single-cycle I/O register port from the core.
// What this block does
// - Enabled pin change sets the flag
// - Flag with both enables requests the vector
// - Flag clears on entry or write one
// - Mask at 0x10, reset zero, bits 3:0
// - Masked-off pins never raise the flag
// - Bit set/clear touches only that bit
// - Four addresses per port, pin-in read-only
// - Writing one to pin-in toggles output
// - Global disable kills all pull-ups
// - Direction one output, zero input
// - Input: hi-Z or pull-up per enable
// - Output drives value; pull-up may add
// - Reset tri-states pins without clock
// - In-to-out waits one tri-state cycle
// - Break-before-make is one port bit
// - Out-to-in has no tri-state gap
// - Alternate functions leave other pins usable
// - Both enables arm masked pins' interrupt
// - Change detection works without I/O clock
// - Inputs pass a two-stage synchroniser
`include "gpc_defs.svh"
module gpc_port #(
    parameter int PINS = 4 // Pins in the port
) (
    input wire logic clock_i, // System clock, 125 MHz
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic [`GPC_ADDR_W-1:0] io_addr_i, // I/O register address
    input wire logic io_wr_i, // Write strobe
    input wire logic [7:0] io_wdata_i, // Write data
    input wire logic io_bit_op_i, // Single-bit set/clear access
    input wire logic [2:0] io_bit_sel_i, // Bit for bit access
    input wire logic io_bit_val_i, // Value for bit access
    output logic [7:0] io_rdata_o, // Read data, combinational on address
    input wire logic global_irq_en_i, // Core interrupt enable bit
    input wire logic irq_ack_i, // Core enters pin-change routine
    output logic irq_req_o, // Pin-change vector request
    output logic wake_o, // Asynchronous wake on masked change
    input wire logic [PINS-1:0] alt_pin_en_i, // Alternate function owns pin
    input wire logic [PINS-1:0] alt_oe_i, // Alternate output enable
    input wire logic [PINS-1:0] alt_out_i, // Alternate output value
    input wire logic [PINS-1:0] pin_i, // Pad input level
    output logic [PINS-1:0] pin_o, // Pad output level
    output logic [PINS-1:0] pin_oe_o, // Pad output enable
    output logic [PINS-1:0] pullup_o, // Pad pull-up enable
    output logic [PINS-1:0] pin_sync_o // Synchronised pin levels
);
    logic [PINS-1:0] dir_reg, dir_next;
    logic [PINS-1:0] out_value_reg, out_value_next;
    logic [PINS-1:0] pullup_en_reg, pullup_en_next;
    logic [PINS-1:0] mask_reg, mask_next;
    logic [PINS-1:0] prev_reg, prev_next;
    logic pud_reg, pud_next;
    logic bbm_reg, bbm_next;
    logic pcie_reg, pcie_next;
    gpc_pkg::gpc_flag_state_t flag_state_reg, flag_state_next;
    logic [PINS-1:0] synced;
    logic [PINS-1:0] gpio_out, gpio_oe;
    logic [7:0] wr_byte;
    logic [7:0] cur_byte;
    logic change;
    logic flag;

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            gpc_pin_sync u_sync (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .pin_i(pin_i[g]),
                .sync_o(synced[g])
            );
            gpc_pin_drive u_drive (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .dir_bit_i(dir_reg[g]),
                .out_value_bit_i(out_value_reg[g]),
                .pullup_en_bit_i(pullup_en_reg[g]),
                .global_pullup_disable_i(pud_reg),
                .break_before_make_en_i(bbm_reg),
                .pin_o(gpio_out[g]),
                .pin_oe_o(gpio_oe[g]),
                .pullup_o(pullup_o[g])
            );
        end
    endgenerate

    // Per-pin override only; other pins keep their own controls
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pin_o[i] = alt_pin_en_i[i] ? alt_out_i[i] : gpio_out[i];
            pin_oe_o[i] = alt_pin_en_i[i] ? (alt_oe_i[i] && !reset_i) : gpio_oe[i];
        end
    end
    assign pin_sync_o = synced;

    // Current value of the addressed register, for bit access merge
    always_comb begin
        cur_byte = `GPC_RST_BYTE;
        case (io_addr_i)
            `GPC_OFF_DIR: cur_byte[PINS-1:0] = dir_reg;
            `GPC_OFF_OUT_VAL: cur_byte[PINS-1:0] = out_value_reg;
            `GPC_OFF_PULLUP: cur_byte[PINS-1:0] = pullup_en_reg;
            `GPC_OFF_CPU_CTRL: cur_byte[`GPC_BIT_PUD] = pud_reg;
            `GPC_OFF_PORT_CTRL: cur_byte[`GPC_BIT_BBM] = bbm_reg;
            `GPC_OFF_PC_CTRL: cur_byte[`GPC_BIT_PCIE] = pcie_reg;
            `GPC_OFF_PC_MASK: cur_byte[PINS-1:0] = mask_reg;
            default: cur_byte = `GPC_RST_BYTE;
        endcase
    end

    // Bit ops merge one bit into the current value, sparing its neighbours
    always_comb begin
        wr_byte = io_wdata_i;
        if (io_bit_op_i) begin
            wr_byte = cur_byte;
            wr_byte[io_bit_sel_i] = io_bit_val_i;
            // Write-one toggle/clear locations act on the single bit only
            if (io_addr_i == `GPC_OFF_PIN_IN || io_addr_i == `GPC_OFF_PC_FLAG) begin
                wr_byte = `GPC_RST_BYTE;
                wr_byte[io_bit_sel_i] = io_bit_val_i;
            end
        end
    end

    always_comb begin
        io_rdata_o = cur_byte;
        if (io_addr_i == `GPC_OFF_PIN_IN) begin
            io_rdata_o[PINS-1:0] = synced;
        end
        if (io_addr_i == `GPC_OFF_PC_FLAG) begin
            io_rdata_o[`GPC_BIT_PCIF] = flag;
        end
    end

    // Register writes; pin-in writes toggle output instead of storing
    always_comb begin
        dir_next = dir_reg;
        out_value_next = out_value_reg;
        pullup_en_next = pullup_en_reg;
        mask_next = mask_reg;
        pud_next = pud_reg;
        bbm_next = bbm_reg;
        pcie_next = pcie_reg;
        if (io_wr_i) begin
            case (io_addr_i)
                `GPC_OFF_PIN_IN: out_value_next = out_value_reg ^ wr_byte[PINS-1:0];
                `GPC_OFF_DIR: dir_next = wr_byte[PINS-1:0];
                `GPC_OFF_OUT_VAL: out_value_next = wr_byte[PINS-1:0];
                `GPC_OFF_PULLUP: pullup_en_next = wr_byte[PINS-1:0];
                `GPC_OFF_CPU_CTRL: pud_next = wr_byte[`GPC_BIT_PUD];
                `GPC_OFF_PORT_CTRL: bbm_next = wr_byte[`GPC_BIT_BBM];
                `GPC_OFF_PC_CTRL: pcie_next = wr_byte[`GPC_BIT_PCIE];
                `GPC_OFF_PC_MASK: mask_next = wr_byte[PINS-1:0];
                default: ;
            endcase
        end
    end

    // Change on an unmasked pin in synchronised domain
    always_comb begin
        prev_next = synced;
        change = |((synced ^ prev_reg) & mask_reg);
    end
    // Raw-pin comparison needs no clock; lets sleep logic wake the core
    assign wake_o = |((pin_i ^ prev_reg) & mask_reg) && pcie_reg;

    // Flag keeper: set wins over ack or write-one clear
    logic clr;
    assign clr = irq_ack_i || (io_wr_i && io_addr_i == `GPC_OFF_PC_FLAG && wr_byte[`GPC_BIT_PCIF]);
    always_comb begin
        flag_state_next = flag_state_reg;
        case (flag_state_reg)
            gpc_pkg::GPC_FLAG_IDLE: begin
                if (change) begin
                    flag_state_next = gpc_pkg::GPC_FLAG_SET;
                end
            end
            gpc_pkg::GPC_FLAG_SET: begin
                if (clr && !change) begin
                    flag_state_next = gpc_pkg::GPC_FLAG_ACK;
                end
            end
            gpc_pkg::GPC_FLAG_ACK: begin
                flag_state_next = change ? gpc_pkg::GPC_FLAG_SET : gpc_pkg::GPC_FLAG_IDLE;
            end
            default: flag_state_next = gpc_pkg::GPC_FLAG_IDLE;
        endcase
    end
    assign flag = (flag_state_reg == gpc_pkg::GPC_FLAG_SET);
    assign irq_req_o = flag && pcie_reg && global_irq_en_i;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dir_reg <= PINS'(`GPC_RST_NIB);
            out_value_reg <= PINS'(`GPC_RST_NIB);
            pullup_en_reg <= PINS'(`GPC_RST_NIB);
            mask_reg <= PINS'(`GPC_RST_NIB);
            prev_reg <= PINS'(`GPC_RST_NIB);
            pud_reg <= 1'b0;
            bbm_reg <= 1'b0;
            pcie_reg <= 1'b0;
            flag_state_reg <= gpc_pkg::GPC_FLAG_IDLE;
        end else begin
            dir_reg <= dir_next;
            out_value_reg <= out_value_next;
            pullup_en_reg <= pullup_en_next;
            mask_reg <= mask_next;
            prev_reg <= prev_next;
            pud_reg <= pud_next;
            bbm_reg <= bbm_next;
            pcie_reg <= pcie_next;
            flag_state_reg <= flag_state_next;
        end
    end
endmodule // gpc_port

// *** rtl/gpc_defs.svh ***
// Register offsets, field positions and reset values for the pin-change GPIO port.
// Included by the port and pin-driver design files of the block; holds definitions only.
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

`define GPC_ADDR_W 6
`define GPC_OFF_PIN_IN 6'h00
`define GPC_OFF_DIR 6'h01
`define GPC_OFF_OUT_VAL 6'h02
`define GPC_OFF_PULLUP 6'h03
`define GPC_OFF_CPU_CTRL 6'h04
`define GPC_OFF_PORT_CTRL 6'h05
`define GPC_OFF_PC_CTRL 6'h06
`define GPC_OFF_PC_FLAG 6'h07
`define GPC_OFF_PC_MASK 6'h10
`define GPC_BIT_PUD 4
`define GPC_BIT_BBM 0
`define GPC_BIT_PCIE 0
`define GPC_BIT_PCIF 0
`define GPC_RST_BYTE 8'h00
`define GPC_RST_NIB 4'h0

`endif

// *** rtl/gpc_pkg.sv ***
// Types shared by the pin-change GPIO port.
// No assumptions beyond a SystemVerilog compiler.
package gpc_pkg;
    typedef enum logic [2:0] {
        GPC_FLAG_IDLE = 3'b001,
        GPC_FLAG_SET = 3'b010,
        GPC_FLAG_ACK = 3'b100
    } gpc_flag_state_t;
endpackage

// *** rtl/gpc_pin_sync.sv ***
// Two-stage input synchroniser for one port pin.
// Assumes the pin level is free-running and asynchronous to clock_i.
module gpc_pin_sync (
    input wire logic clock_i, // System clock
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic pin_i, // Raw pin level
    output logic sync_o // Synchronised level
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = pin_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule // gpc_pin_sync

// *** rtl/gpc_pin_drive.sv ***
// Output driver control for one pin: direction, break-before-make, pull-up.
// Assumes reset_i is also usable combinationally to force tri-state.
`include "gpc_defs.svh"
module gpc_pin_drive (
    input wire logic clock_i, // System clock
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic dir_bit_i, // 1 output, 0 input
    input wire logic out_value_bit_i, // Value to drive
    input wire logic pullup_en_bit_i, // Per-pin pull-up enable
    input wire logic global_pullup_disable_i, // Kills every pull-up
    input wire logic break_before_make_en_i, // Port-wide gap on in-to-out
    output logic pin_o, // Driven level
    output logic pin_oe_o, // Output enable, high while driving
    output logic pullup_o // Pull-up active
);
    logic dir_q_reg;
    logic dir_q_next;

    always_comb begin
        dir_q_next = dir_bit_i;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dir_q_reg <= 1'b0;
        end else begin
            dir_q_reg <= dir_q_next;
        end
    end

    // Gap only on a rising direction bit; falling releases at once
    logic gap;
    assign gap = break_before_make_en_i && dir_bit_i && !dir_q_reg;
    // Reset is gated in directly so pins float without waiting for an edge
    assign pin_oe_o = dir_bit_i && !gap && !reset_i;
    assign pin_o = out_value_bit_i;
    assign pullup_o = pullup_en_bit_i && !global_pullup_disable_i && !reset_i;
endmodule // gpc_pin_drive

// *** verification/gpc_checker.sv ***
// Concurrent checks on the pin-change GPIO port.
// Bound to gpc_port below; sees only its ports, alternate inputs held low.
`include "gpc_defs.svh"
module gpc_checker #(
    parameter int PINS = 4 // Pins
) (
    input wire logic clock_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic [`GPC_ADDR_W-1:0] io_addr_i, // Address
    input wire logic io_wr_i, // Write
    input wire logic [7:0] io_wdata_i, // Data
    input wire logic io_bit_op_i, // Bit op
    input wire logic [7:0] io_rdata_o, // Read data
    input wire logic global_irq_en_i, // Core enable
    input wire logic irq_ack_i, // Ack
    input wire logic irq_req_o, // Request
    input wire logic [PINS-1:0] pin_i, // Pad in
    input wire logic [PINS-1:0] pin_o, // Pad out
    input wire logic [PINS-1:0] pin_oe_o, // Pad enable
    input wire logic [PINS-1:0] pullup_o, // Pull-up
    input wire logic [PINS-1:0] pin_sync_o // Synced
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic wr_x;
    assign wr_x = io_wr_i && !io_bit_op_i;
    a_reset_tristate: assert property ($fell(reset_i) |-> $past(pin_oe_o) == '0
        && $past(pullup_o) == '0) else $error("pins active in reset");
    a_mask_reset: assert property ($past(reset_i) && io_addr_i == `GPC_OFF_PC_MASK
        |-> io_rdata_o == 8'h00) else $error("mask not zero after reset");
    a_irq_gate: assert property (irq_req_o |-> global_irq_en_i &&
        (io_addr_i != `GPC_OFF_PC_FLAG || io_rdata_o[`GPC_BIT_PCIF]))
        else $error("request without enable or flag");
    // A pin change in the clearing cycle keeps the flag, so it is left out
    a_ack_clear: assert property (irq_ack_i && $stable(pin_sync_o) |=> !irq_req_o)
        else $error("flag kept after ack");
    a_w1c_clear: assert property (wr_x && io_addr_i == `GPC_OFF_PC_FLAG
        && io_wdata_i[`GPC_BIT_PCIF] && $stable(pin_sync_o) |=> !irq_req_o)
        else $error("flag kept after write one");
    a_toggle_out: assert property (wr_x && io_addr_i == `GPC_OFF_PIN_IN
        |=> pin_o == ($past(pin_o) ^ PINS'($past(io_wdata_i)))) else $error("bad toggle");
    a_dir_release: assert property (wr_x && io_addr_i == `GPC_OFF_DIR
        |=> (pin_oe_o & ~PINS'($past(io_wdata_i))) == '0) else $error("input still driven");
    a_sync_delay: assert property (!$past(reset_i) && !$past(reset_i, 2)
        |-> pin_sync_o == $past(pin_i, 2)) else $error("sync delay wrong");
    a_change_raise: assert property ($rose(irq_req_o) && $stable(global_irq_en_i)
        && !$past(io_wr_i) |-> $past(pin_sync_o) != $past(pin_sync_o, 2))
        else $error("flag without pin change");
endmodule // gpc_checker

bind gpc_port gpc_checker #(.PINS(PINS)) u_chk (.clock_i, .reset_i, .io_addr_i, .io_wr_i,
    .io_wdata_i, .io_bit_op_i, .io_rdata_o, .global_irq_en_i, .irq_ack_i, .irq_req_o,
    .pin_i, .pin_o, .pin_oe_o, .pullup_o, .pin_sync_o);

// *** verification/gpc_pad_model.sv ***
// Board-side pads: port drive, external drivers, pull-ups.
// An undriven pin holds the inverse of its last driven level.
module gpc_pad_model (
    input wire logic clock_i, // Clock
    input wire logic [3:0] port_val_i, // Port value
    input wire logic [3:0] port_oe_i, // Port enable
    input wire logic [3:0] pullup_i, // Pull-up
    input wire logic [3:0] ext_en_i, // External drive on
    input wire logic [3:0] ext_val_i, // External level
    output logic [3:0] pad_o // Pad level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_reg = 4'h0;
    logic [3:0] drv;
    logic [3:0] lvl;
    assign drv = port_oe_i | ext_en_i | pullup_i;
    assign lvl = (port_oe_i & port_val_i) | (~port_oe_i & ext_en_i & ext_val_i)
        | (~port_oe_i & ~ext_en_i & pullup_i);
    assign pad_o = (drv & lvl) | (~drv & ~last_reg);
    always @(posedge clock_i) begin
        last_reg <= (drv & lvl) | (~drv & last_reg);
    end
endmodule // gpc_pad_model

// *** verification/tb_top.sv ***
// Self-checking bench for the pin-change GPIO port.
// Pads come from gpc_pad_model; alternate function inputs held low.
`include "gpc_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic io_wr_i = 1'b0;
    logic io_bit_op_i = 1'b0;
    logic io_bit_val_i = 1'b0;
    logic global_irq_en_i = 1'b0;
    logic irq_ack_i = 1'b0;
    logic [`GPC_ADDR_W-1:0] io_addr_i = '0;
    logic [7:0] io_wdata_i = 8'h00;
    logic [2:0] io_bit_sel_i = 3'h0;
    logic [3:0] ext_en = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic [7:0] io_rdata_o;
    logic irq_req_o;
    logic wake_o;
    logic [3:0] pin_i, pin_o, pin_oe_o, pullup_o, pin_sync_o;
    int failures = 0;
    int check_count = 0;

    always #4 clock_i = ~clock_i;

    gpc_port u_dut (.clock_i, .reset_i, .io_addr_i, .io_wr_i, .io_wdata_i, .io_bit_op_i,
        .io_bit_sel_i, .io_bit_val_i, .io_rdata_o, .global_irq_en_i, .irq_ack_i, .irq_req_o,
        .wake_o, .alt_pin_en_i(4'h0), .alt_oe_i(4'h0), .alt_out_i(4'h0), .pin_i, .pin_o,
        .pin_oe_o, .pullup_o, .pin_sync_o);
    gpc_pad_model u_pads (.clock_i, .port_val_i(pin_o), .port_oe_i(pin_oe_o),
        .pullup_i(pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pin_i));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Bit op packs the value in d[3] and the index in d[2:0]
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic op = 1'b0);
        @(posedge clock_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_bit_op_i <= op;
        io_bit_sel_i <= d[2:0];
        io_bit_val_i <= d[3];
        io_wr_i <= 1'b1;
        @(posedge clock_i);
        io_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        io_addr_i <= a;
        #1;
        chk(io_rdata_o, exp);
    endtask
    // Pins must let go before any edge has acted on the reset
    task automatic do_reset;
        @(posedge clock_i);
        reset_i <= 1'b1;
        #1;
        chk({pullup_o, pin_oe_o}, 8'h00);
        repeat (5) @(posedge clock_i);
        io_addr_i <= `GPC_OFF_PC_MASK;
        reset_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(io_rdata_o, 8'h00);
        $display("reset done");
    endtask
    task automatic wait_req;
        for (int n = 0; n < 8 && irq_req_o !== 1'b1; n++) @(posedge clock_i);
        #1;
        chk({7'h0, irq_req_o}, 8'h01);
    endtask
    task automatic t_regs;
        wr(`GPC_OFF_PC_MASK, 8'hFF);
        rd(`GPC_OFF_PC_MASK, 8'h0F);
        wr(`GPC_OFF_DIR, 8'h05);
        wr(`GPC_OFF_DIR, 8'h09, 1'b1);
        rd(`GPC_OFF_DIR, 8'h07);
        wr(`GPC_OFF_DIR, 8'h00, 1'b1);
        rd(`GPC_OFF_DIR, 8'h06);
        wr(6'h3F, 8'hFF);
        rd(6'h3F, 8'h00);
        wr(`GPC_OFF_OUT_VAL, 8'h03);
        wr(`GPC_OFF_PIN_IN, 8'h05);
        rd(`GPC_OFF_OUT_VAL, 8'h06);
        wr(`GPC_OFF_PIN_IN, 8'h00);
        rd(`GPC_OFF_OUT_VAL, 8'h06);
        $display("regs done");
    endtask
    task automatic t_drive;
        wr(`GPC_OFF_DIR, 8'h0C);
        chk({pin_oe_o, pin_o & pin_oe_o}, 8'hC4);
        wr(`GPC_OFF_PULLUP, 8'h0A);
        chk({4'h0, pullup_o}, 8'h0A);
        wr(`GPC_OFF_PULLUP, 8'h08, 1'b1);
        chk({4'h0, pullup_o}, 8'h0B);
        wr(`GPC_OFF_CPU_CTRL, 8'h10);
        chk({4'h0, pullup_o}, 8'h00);
        wr(`GPC_OFF_CPU_CTRL, 8'h00);
        wr(`GPC_OFF_PULLUP, 8'h00);
        wr(`GPC_OFF_PORT_CTRL, 8'h01);
        wr(`GPC_OFF_DIR, 8'h0D);
        chk({4'h0, pin_oe_o}, 8'h0C);
        @(posedge clock_i);
        #1;
        chk({4'h0, pin_oe_o}, 8'h0D);
        wr(`GPC_OFF_DIR, 8'h0C);
        chk({4'h0, pin_oe_o}, 8'h0C);
        wr(`GPC_OFF_PORT_CTRL, 8'h00);
        wr(`GPC_OFF_DIR, 8'h0D);
        chk({4'h0, pin_oe_o}, 8'h0D);
        wr(`GPC_OFF_DIR, 8'h00);
        $display("drive done");
    endtask
    task automatic t_irq;
        @(posedge clock_i);
        ext_en <= 4'h3;
        ext_val <= 4'h0;
        wr(`GPC_OFF_PC_MASK, 8'h01);
        repeat (4) @(posedge clock_i);
        wr(`GPC_OFF_PC_FLAG, 8'h01);
        wr(`GPC_OFF_PC_CTRL, 8'h01);
        @(posedge clock_i);
        global_irq_en_i <= 1'b1;
        ext_val <= 4'h2;
        repeat (6) @(posedge clock_i);
        #1;
        chk({7'h0, irq_req_o}, 8'h00);
        @(posedge clock_i);
        ext_val <= 4'h3;
        #1;
        chk({7'h0, wake_o}, 8'h01);
        wait_req();
        rd(`GPC_OFF_PC_FLAG, 8'h01);
        // Pins 0 and 1 held high outside, 2 and 3 floating at the model's inverse
        rd(`GPC_OFF_PIN_IN, 8'h0B);
        @(posedge clock_i);
        global_irq_en_i <= 1'b0;
        #1;
        chk({7'h0, irq_req_o}, 8'h00);
        @(posedge clock_i);
        global_irq_en_i <= 1'b1;
        irq_ack_i <= 1'b1;
        @(posedge clock_i);
        irq_ack_i <= 1'b0;
        rd(`GPC_OFF_PC_FLAG, 8'h00);
        ext_val <= 4'h2;
        wait_req();
        wr(`GPC_OFF_PC_FLAG, 8'h01);
        chk({7'h0, irq_req_o}, 8'h00);
        $display("irq done");
    endtask

    task automatic end_sim;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge clock_i);
        failures++;
        $display("[ERR] %0t timeout", $time);
        end_sim();
    end

    initial begin
        do_reset();
        t_regs();
        t_drive();
        t_irq();
        wr(`GPC_OFF_DIR, 8'h0F);
        wr(`GPC_OFF_PULLUP, 8'h0F);
        do_reset();
        end_sim();
    end
endmodule // tb_top
